// ==== uic_top.sv ====
// Purpose: masked status, clear, mask and ident registers over AXI4-Lite
// Assumes: source events arrive as one-cycle pulses on this clock
// Notes:   one write and one read in flight; reads take three cycles
// Functional notes
// [RL1] masked status bits 10..4, reset zero
// [RL2] masked status at 0x040, writes ignored
// [RL3] masked bit is raw AND mask, combinational
// [RL4] clear register decoded at 0x044
// [RL5] writing one clears the raw flag
// [RL6] writing zero leaves the flag alone
// [RL7] clear bits 10..4 map all seven sources
// [RL8] bit 9 clears only the break flag
// [RL9] clear bits 31:11, 3:0 reserved, untouched
// [RL10] ident words are fixed, writes ignored
// [RL11] ident 4..7 at 0xFD0..0xFDC, 0 at 0xFE0
`timescale 1ns/1ps
`include "uic_cfg.svh"
module uic_top #(
  parameter int         ADDR_W = 12,
  parameter logic [7:0] IDENT4 = `UIC_IDENT4_VAL,
  parameter logic [7:0] IDENT5 = `UIC_IDENT5_VAL,
  parameter logic [7:0] IDENT6 = `UIC_IDENT6_VAL,
  parameter logic [7:0] IDENT7 = `UIC_IDENT7_VAL,
  parameter logic [7:0] IDENT0 = `UIC_IDENT0_VAL
) (
  input  wire logic              clock,          // 20 MHz clock
  input  wire logic              reset,          // sync, active high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // byte enables
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire uic_pkg::uic_src_t srcEvent,       // source event pulses
  output logic                   irq             // level interrupt
);

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
    $error("uic_top: ADDR_W must lie in 12..32");
  end

  // ****************************************************************
  // internal state
  // ****************************************************************
  uic_flag_if             flags ();
  uic_pkg::uic_src_t      maskBits;
  uic_pkg::uic_src_t      maskedIrq;
  uic_pkg::uic_rd_state_t rdState;
  logic [ADDR_W-1:0]      wrAddr;
  logic [31:0]            wrData;
  logic [3:0]             wrStrb;
  logic                   awHeld;
  logic                   wHeld;
  logic                   wrFire;
  logic [ADDR_W-1:0]      rdAddr;
  logic [2:0]             romIdx;
  logic                   romHit;
  logic [31:0]            romData;
  logic [1:0]             next_bresp;
  uic_pkg::uic_src_t      wrSrcBits;

  // ****************************************************************
  // address compare on word addresses
  // ****************************************************************
  function automatic logic isAt(input logic [ADDR_W-1:0] a,
                                input logic [11:0]       off);
    isAt = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[11:2]));
  endfunction

  function automatic logic [31:0] place(input uic_pkg::uic_src_t v);
    place = {21'h00_0000, v, 4'h0};
  endfunction

  // ****************************************************************
  // interrupt status and output
  // ****************************************************************
  assign maskedIrq = flags.rawFlag & maskBits; // RL3 RL1
  assign irq       = |maskedIrq;

  uic_flag_bank i_uic_flag_bank (
    .clock    (clock),
    .reset    (reset),
    .srcEvent (srcEvent),
    .flags    (flags)
  );

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign wrFire        = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (reset) begin
      awHeld <= 1'b0;
      wrAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      wrAddr <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wHeld  <= 1'b0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  // only bits 10..4 reach the flags; bits 31:11 and 3:0 are dropped
  assign wrSrcBits = wrData[`UIC_SRC_LSB +: `UIC_SRC_N] &
                     {{3{wrStrb[1]}}, {4{wrStrb[0]}}}; // RL7 RL9

  // strobe lands one edge later in the flag bank
  assign flags.clearPulse = (wrFire && isAt(wrAddr, `UIC_OFF_ICR)) ?
                            wrSrcBits : 7'h00; // RL4 RL5 RL6 RL8

  always_comb begin
    next_bresp = `UIC_RESP_SLVERR;
    if (isAt(wrAddr, `UIC_OFF_MASK) || isAt(wrAddr, `UIC_OFF_RAW) ||
        isAt(wrAddr, `UIC_OFF_MIS)  || isAt(wrAddr, `UIC_OFF_ICR)) begin
      next_bresp = `UIC_RESP_OKAY;
    end else if (romHit) begin
      next_bresp = `UIC_RESP_OKAY;
    end
  end

  // read-only words answer OKAY but keep their value
  always_ff @(posedge clock) begin
    if (reset) begin
      maskBits <= `UIC_MASK_RESET;
    end else if (wrFire && isAt(wrAddr, `UIC_OFF_MASK)) begin
      maskBits <= (maskBits & ~{{3{wrStrb[1]}}, {4{wrStrb[0]}}}) |
                  wrSrcBits;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UIC_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // romHit decodes the write address; it is unused by the read path
  always_comb begin
    romHit = isAt(wrAddr, `UIC_OFF_ID4) || isAt(wrAddr, `UIC_OFF_ID5) ||
             isAt(wrAddr, `UIC_OFF_ID6) || isAt(wrAddr, `UIC_OFF_ID7) ||
             isAt(wrAddr, `UIC_OFF_ID0);
  end

  // ****************************************************************
  // read channel: address, rom fetch, mux, answer
  // ****************************************************************
  assign s_axi_arready = (rdState == uic_pkg::RD_IDLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      rdState <= uic_pkg::RD_IDLE;
      rdAddr  <= '0;
    end else begin
      unique case (rdState)
        uic_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rdAddr  <= s_axi_araddr;
            rdState <= uic_pkg::RD_ROM;
          end
        end
        uic_pkg::RD_ROM: begin
          rdState <= uic_pkg::RD_MUX;
        end
        uic_pkg::RD_MUX: begin
          rdState <= uic_pkg::RD_RESP;
        end
        uic_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            rdState <= uic_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    romIdx = 3'h7;
    if (isAt(rdAddr, `UIC_OFF_ID4)) begin
      romIdx = 3'h0; // RL11
    end else if (isAt(rdAddr, `UIC_OFF_ID5)) begin
      romIdx = 3'h1;
    end else if (isAt(rdAddr, `UIC_OFF_ID6)) begin
      romIdx = 3'h2;
    end else if (isAt(rdAddr, `UIC_OFF_ID7)) begin
      romIdx = 3'h3;
    end else if (isAt(rdAddr, `UIC_OFF_ID0)) begin
      romIdx = 3'h4;
    end
  end

  uic_ident_rom #(
    .IDENT4 (IDENT4),
    .IDENT5 (IDENT5),
    .IDENT6 (IDENT6),
    .IDENT7 (IDENT7),
    .IDENT0 (IDENT0)
  ) i_uic_ident_rom (
    .clock (clock),
    .reset (reset),
    .en    (rdState == uic_pkg::RD_ROM),
    .idx   (romIdx),
    .data  (romData)
  );

  // masked value is sampled in the mux cycle, not at the address edge
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `UIC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
    end else if (rdState == uic_pkg::RD_MUX) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `UIC_RESP_OKAY;
      if (isAt(rdAddr, `UIC_OFF_MIS)) begin
        s_axi_rdata <= place(maskedIrq); // RL1 RL2
      end else if (isAt(rdAddr, `UIC_OFF_RAW)) begin
        s_axi_rdata <= place(flags.rawFlag);
      end else if (isAt(rdAddr, `UIC_OFF_MASK)) begin
        s_axi_rdata <= place(maskBits);
      end else if (isAt(rdAddr, `UIC_OFF_ICR)) begin
        s_axi_rdata <= 32'h0000_0000; // RL9
      end else if (romIdx != 3'h7) begin
        s_axi_rdata <= romData; // RL10 RL11
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `UIC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_mis_write_inert: assert property (@(posedge clock) disable iff (reset)
    wrFire && isAt(wrAddr, `UIC_OFF_MIS) |=>
      flags.rawFlag == ($past(flags.rawFlag) | $past(srcEvent)))
    else $error("status write changed a flag"); // RL2

  a_mis_and_mask: assert property (@(posedge clock) disable iff (reset)
    $rose(s_axi_rvalid) && isAt(rdAddr, `UIC_OFF_MIS) |->
      s_axi_rdata[10:4] == $past(flags.rawFlag & maskBits))
    else $error("status read differs from raw and mask"); // RL3

  a_mis_read_layout: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && isAt(rdAddr, `UIC_OFF_MIS) |->
      s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:11] == 21'h00_0000)
    else $error("status read reserved bits set"); // RL1

  a_icr_decode: assert property (@(posedge clock) disable iff (reset)
    wrFire && isAt(wrAddr, `UIC_OFF_ICR) && wrStrb == 4'hF |->
      flags.clearPulse == wrData[10:4])
    else $error("clear strobe mismatch"); // RL4 RL7

  a_clear_only_icr: assert property (@(posedge clock) disable iff (reset)
    !(wrFire && isAt(wrAddr, `UIC_OFF_ICR)) |-> flags.clearPulse == 7'h00)
    else $error("clear strobe outside clear write"); // RL6

  a_break_only: assert property (@(posedge clock) disable iff (reset)
    wrFire && isAt(wrAddr, `UIC_OFF_ICR) && wrData[10:4] == 7'h20 &&
      wrStrb[1] |-> ##1 (flags.rawFlag & ~$past(flags.rawFlag) &
      ~$past(srcEvent)) == 7'h00 && flags.rawFlag[5] == $past(srcEvent[5])
      && ($past(flags.rawFlag) & ~flags.rawFlag & 7'h5F) == 7'h00)
    else $error("break clear touched another flag"); // RL8

  a_ident_fixed: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && isAt(rdAddr, `UIC_OFF_ID4) |->
      s_axi_rdata == {24'h00_0000, IDENT4})
    else $error("ident 4 read wrong"); // RL10 RL11

  a_ident0_fixed: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && isAt(rdAddr, `UIC_OFF_ID0) |->
      s_axi_rdata == {24'h00_0000, IDENT0} && s_axi_rresp == 2'h0)
    else $error("ident 0 read wrong"); // RL11

  a_read_latency: assert property (@(posedge clock) disable iff (reset)
    s_axi_arvalid && s_axi_arready |-> !s_axi_rvalid ##3 s_axi_rvalid)
    else $error("read answer not in three cycles");

  a_write_answer: assert property (@(posedge clock) disable iff (reset)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges after take");

  a_ready_held: assert property (@(posedge clock) disable iff (reset)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write beat accepted while answer pending");

  a_icr_read_zero: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && isAt(rdAddr, `UIC_OFF_ICR) |-> s_axi_rdata == 32'h0)
    else $error("clear register read not zero"); // RL9

  a_ident_write_ok: assert property (@(posedge clock) disable iff (reset)
    wrFire && romHit |=> s_axi_bresp == `UIC_RESP_OKAY)
    else $error("ident write not answered okay"); // RL10

  a_read_unmapped: assert property (@(posedge clock) disable iff (reset)
    s_axi_rvalid && isAt(rdAddr, 12'hFE4) |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");

  a_reset_clear: assert property (@(posedge clock)
    $past(reset) |-> maskedIrq == 7'h00 && !irq)
    else $error("status not zero after reset"); // RL1

endmodule

// ==== uic_cfg.svh ====
// Purpose: offsets, field positions and reset values of the irq block
// Assumes: 12-bit byte address space, 32-bit data words
// Notes:   included by its bare name
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define UIC_OFF_MASK     12'h038
`define UIC_OFF_RAW      12'h03C
`define UIC_OFF_MIS      12'h040
`define UIC_OFF_ICR      12'h044
`define UIC_OFF_ID4      12'hFD0
`define UIC_OFF_ID5      12'hFD4
`define UIC_OFF_ID6      12'hFD8
`define UIC_OFF_ID7      12'hFDC
`define UIC_OFF_ID0      12'hFE0

// ****************************************************************
// field layout: sources 0..6 sit at bits 4..10
// ****************************************************************
`define UIC_SRC_LSB      4
`define UIC_SRC_N        7
`define UIC_BRK_IDX      5
`define UIC_MASK_RESET   7'h00
`define UIC_RAW_RESET    7'h00

// ****************************************************************
// identification values (arbitrary, neutral)
// ****************************************************************
`define UIC_IDENT4_VAL   8'h11
`define UIC_IDENT5_VAL   8'h22
`define UIC_IDENT6_VAL   8'h33
`define UIC_IDENT7_VAL   8'h44
`define UIC_IDENT0_VAL   8'h55
`define UIC_IDENT_N      5

// ****************************************************************
// bus answers
// ****************************************************************
`define UIC_RESP_OKAY    2'h0
`define UIC_RESP_SLVERR  2'h2

`endif

// ==== uic_pkg.sv ====
// Purpose: shared types of the irq clear and ident block
// Assumes: constants live in uic_cfg.svh
// Notes:   nothing here is imported; use uic_pkg::name
package uic_pkg;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_ROM,
    RD_MUX,
    RD_RESP
  } uic_rd_state_t;

  typedef logic [6:0] uic_src_t;

endpackage

// ==== uic_flag_if.sv ====
// Purpose: link between bus front end and raw flag bank
// Assumes: one clock domain
// Notes:   clearPulse is a one-cycle strobe per source
`timescale 1ns/1ps
interface uic_flag_if;
  uic_pkg::uic_src_t clearPulse;
  uic_pkg::uic_src_t rawFlag;

  modport front (output clearPulse, input rawFlag);
  modport bank  (input clearPulse, output rawFlag);
endinterface

// ==== uic_flag_bank.sv ====
// Purpose: sticky raw interrupt flags, set by events, cleared by strobe
// Assumes: events come from logic on the same clock
// Notes:   set beats clear in the same cycle
`timescale 1ns/1ps
`include "uic_cfg.svh"
module uic_flag_bank (
  input  wire logic              clock,     // peripheral clock
  input  wire logic              reset,     // sync, active high
  input  wire uic_pkg::uic_src_t srcEvent,  // one-cycle source events
  uic_flag_if.bank               flags      // clear in, raw out
);

  // ****************************************************************
  // one sticky flag per source
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < `UIC_SRC_N; i++) begin : g_flag
      always_ff @(posedge clock) begin
        if (reset) begin
          flags.rawFlag[i] <= 1'b0;
        end else if (srcEvent[i]) begin
          flags.rawFlag[i] <= 1'b1;
        end else if (flags.clearPulse[i]) begin
          flags.rawFlag[i] <= 1'b0; // RL5 RL6
        end
      end
    end
  endgenerate

  a_clear_drops_flag: assert property (@(posedge clock) disable iff (reset)
    |(flags.clearPulse & ~srcEvent) |=>
      (flags.rawFlag & $past(flags.clearPulse & ~srcEvent)) == 7'h00)
    else $error("cleared flag still set"); // RL5
  a_zero_keeps_flag: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> (($past(flags.rawFlag) & ~$past(flags.clearPulse))
      & ~flags.rawFlag) == 7'h00)
    else $error("flag lost without clear"); // RL6
  a_event_sets_flag: assert property (@(posedge clock) disable iff (reset)
    |srcEvent |=> (flags.rawFlag & $past(srcEvent)) == $past(srcEvent))
    else $error("event did not set flag");

endmodule

// ==== uic_ident_rom.sv ====
// Purpose: hard-coded identification words, registered read port
// Assumes: index valid only when en is high
// Notes:   contents fixed at elaboration, writes cannot reach it
`timescale 1ns/1ps
`include "uic_cfg.svh"
module uic_ident_rom #(
  parameter logic [7:0] IDENT4 = `UIC_IDENT4_VAL,
  parameter logic [7:0] IDENT5 = `UIC_IDENT5_VAL,
  parameter logic [7:0] IDENT6 = `UIC_IDENT6_VAL,
  parameter logic [7:0] IDENT7 = `UIC_IDENT7_VAL,
  parameter logic [7:0] IDENT0 = `UIC_IDENT0_VAL
) (
  input  wire logic        clock,    // peripheral clock
  input  wire logic        reset,    // sync, active high
  input  wire logic        en,       // read enable
  input  wire logic [2:0]  idx,      // 0..4 = ident 4,5,6,7,0
  output logic      [31:0] data      // registered word
);

  always_ff @(posedge clock) begin
    if (reset) begin
      data <= 32'h0000_0000;
    end else if (en) begin
      unique case (idx)
        3'h0:    data <= {24'h00_0000, IDENT4}; // RL10
        3'h1:    data <= {24'h00_0000, IDENT5};
        3'h2:    data <= {24'h00_0000, IDENT6};
        3'h3:    data <= {24'h00_0000, IDENT7};
        3'h4:    data <= {24'h00_0000, IDENT0};
        default: data <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== test_uart_irq_clear_and_id_regs.sv ====
// Purpose: self-checking bench for the irq clear and ident block
// Assumes: responses come back within a few cycles of each request
// Notes:   bready and rready stay high, which AXI4-Lite allows
`timescale 1ns/1ps
`include "uic_cfg.svh"
module test_uart_irq_clear_and_id_regs;
  logic              clock;
  logic              reset;
  logic [11:0]       awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [11:0]       araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  uic_pkg::uic_src_t srcEvent;
  logic              irq;
  int                miscompares;
  int                checks;
  int                cycles;
  logic [1:0]        resp;

  uic_top i_uic_top (
    .clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .srcEvent(srcEvent), .irq(irq)
  );

  // ************************************************************
  // clock, timeout and verdict
  // ************************************************************
  initial clock = 1'b0;
  always #25 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ceiling is far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
  endtask

  // read a word and expect it with an OKAY answer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, `UIC_RESP_OKAY});
  endtask

  task automatic wrok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    check({30'h0, r}, {30'h0, `UIC_RESP_OKAY});
  endtask

  // one-cycle event pulse, then a spare edge so drives never collide
  task automatic pulse(input uic_pkg::uic_src_t e);
    srcEvent <= e;
    @(posedge clock);
    srcEvent <= 7'h00;
    @(posedge clock);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rdchk(`UIC_OFF_MIS, 32'h0000_0000);
    rdchk(`UIC_OFF_ICR, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_ident;
    logic [11:0] offs [5];
    logic [7:0]  vals [5];
    logic [31:0] d;
    logic [1:0]  r;
    offs = '{`UIC_OFF_ID4, `UIC_OFF_ID5, `UIC_OFF_ID6, `UIC_OFF_ID7,
             `UIC_OFF_ID0};
    vals = '{`UIC_IDENT4_VAL, `UIC_IDENT5_VAL, `UIC_IDENT6_VAL,
             `UIC_IDENT7_VAL, `UIC_IDENT0_VAL};
    for (int i = 0; i < 5; i++) begin
      rdchk(offs[i], {24'h0, vals[i]});
      wrok(offs[i], 32'hFFFF_FFFF);
      rdchk(offs[i], {24'h0, vals[i]});
    end
    rd(12'hFE4, d, r);
    check({30'h0, r}, {30'h0, `UIC_RESP_SLVERR});
    wr(12'hFE4, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, `UIC_RESP_SLVERR});
    $display("test ident done");
  endtask

  task automatic t_masked;
    pulse(7'h7F);
    rdchk(`UIC_OFF_RAW, 32'h0000_07F0);
    rdchk(`UIC_OFF_MIS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    // only lane 0 is enabled, so bits 10:8 of the mask stay clear
    wr(`UIC_OFF_MASK, 32'h0000_07F0, 4'h1, resp);
    rdchk(`UIC_OFF_MIS, 32'h0000_00F0);
    wrok(`UIC_OFF_MASK, 32'h0000_07F0);
    rdchk(`UIC_OFF_MIS, 32'h0000_07F0);
    check({31'h0, irq}, 32'h0000_0001);
    wrok(`UIC_OFF_MIS, 32'h0000_0000);
    rdchk(`UIC_OFF_MIS, 32'h0000_07F0);
    wrok(`UIC_OFF_ICR, 32'h0000_0000);
    rdchk(`UIC_OFF_RAW, 32'h0000_07F0);
    $display("test masked done");
  endtask

  task automatic t_clear_each;
    logic [31:0] bitv;
    for (int i = 0; i < 7; i++) begin
      bitv = 32'h0000_0010 << i;
      pulse(7'h7F);
      wrok(`UIC_OFF_ICR, bitv);
      rdchk(`UIC_OFF_RAW, 32'h0000_07F0 & ~bitv);
      rdchk(`UIC_OFF_MIS, 32'h0000_07F0 & ~bitv);
    end
    wrok(`UIC_OFF_ICR, 32'h0000_07F0);
    rdchk(`UIC_OFF_MIS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test clear each done");
  endtask

  task automatic t_partial;
    wrok(`UIC_OFF_MASK, 32'h0000_0210);
    pulse(7'h7F);
    rdchk(`UIC_OFF_MIS, 32'h0000_0210);
    wrok(`UIC_OFF_ICR, 32'h0000_0010);
    rdchk(`UIC_OFF_MIS, 32'h0000_0200);
    check({31'h0, irq}, 32'h0000_0001);
    wrok(`UIC_OFF_ICR, 32'h0000_0200);
    rdchk(`UIC_OFF_RAW, 32'h0000_05E0);
    rdchk(`UIC_OFF_MIS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test partial mask done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    miscompares = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b1;
    srcEvent = 7'h00;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_ident();
    t_masked();
    t_clear_each();
    t_partial();
    tally_and_finish();
  end
endmodule
